// File: core/tone_pkg.sv
package tone_pkg;
  // ----------------------------------------------------------------
  // register map (printed offsets are word indexes)
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int IDX_CONTROL = 'hff44;
  localparam int IDX_PITCH_LOUD = 'hff45;
  // tone_control fields
  localparam int CTL_TONE_EN = 0;
  localparam int CTL_DECAY_EN = 1;
  localparam int CTL_DECAY_RST = 2;
  localparam int CTL_STEP_SEL = 3;
  localparam int CTL_LEN_SEL = 4;
  localparam int CTL_TRIGGER = 5;
  localparam int CTL_ABORT = 6;
  // tone_pitch_loudness fields
  localparam int PL_PITCH_LSB = 0;
  localparam int PL_LOUD_LSB = 4;
  // reset values
  localparam logic [2:0] PITCH_RESET = 3'h0;
  localparam logic [2:0] LOUD_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // timing, counted in slow-oscillator half periods
  // ----------------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int HALF_HZ = 2 * OSC_HZ;
  localparam int SYNC_HZ = 256;
  localparam int STEP_FAST_HZ = 16;
  localparam int STEP_SLOW_HZ = 8;
  localparam int DIV_SYNC = HALF_HZ / SYNC_HZ;
  localparam int DIV_FAST = HALF_HZ / STEP_FAST_HZ;
  localparam int DIV_SLOW = HALF_HZ / STEP_SLOW_HZ;
  localparam int DIV_W = 13;
  localparam int SHOT_LONG_US = 125000;
  localparam int SHOT_SHORT_US = 31250;
  localparam logic [5:0] SHOT_LONG_TICKS = 6'(SHOT_LONG_US * SYNC_HZ / 1000000);
  localparam logic [5:0] SHOT_SHORT_TICKS = 6'(SHOT_SHORT_US * SYNC_HZ / 1000000);
  localparam logic [2:0] LEVEL_MAX = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  typedef enum logic [1:0] {
    SHOT_IDLE = 2'b00,
    SHOT_WAIT = 2'b01,
    SHOT_RUN = 2'b10
  } shot_state_t;
endpackage

// File: core/buzzer_tone_generator.sv
// Notes on behaviour
// - tone_enable or a running one-shot burst drives tone_signal onto tone_pin, else pin low; tone_enable resets to 0
// - three-bit pitch_sel picks eight tones 4096.0 down to 1170.3 Hz
// - pitch_sel resets to 000, the 4096.0 Hz tone
// - loudness_sel picks duty levels 1 to 8, period 16/20/24/28 units
// - with decay_enable set, envelope level replaces loudness_sel
// - loudness_sel resets to 000, level 1 maximum duty
// - decay_restart write of 1 returns envelope to level 1; reads 0
// - decay_enable applies stepped envelope while tone_enable is 1, else fixed level; resets 0
// - writing oneshot_trigger 1 clears decay_enable
// - envelope steps each 125 ms if decay_step_sel, else 62.5 ms
// - decay_step_sel has no effect while decay_enable is 0
// - oneshot_length_sel: 125 ms when 1, 31.25 ms when 0; resets 0
// - oneshot_trigger starts burst which ends after the chosen duration
// - trigger accepted only while tone_enable is 0
// - retrigger during burst restarts the duration count
// - oneshot_trigger reads 1 while burst busy, 0 idle
// - oneshot_abort 1 ends active burst at once; write-only, reads 0
// - trigger and abort in same write: abort wins, circuit stopped
// - burst start and timeout align to 256 Hz tick; abort immediate
// - envelope starts at level 1, steps to 8, holds there
// - every tone derives from the 32.768 kHz slow oscillator
`timescale 1ns/10ps
`default_nettype none
module buzzer_tone_generator #(
  parameter int ADDR_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tone_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tone_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slowOscillator,
  output logic tonePin
);
  import tone_pkg::*;

  generate
    if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 18 to 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] decodeIdx(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_CONTROL)) begin
      return 2'h1;
    end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(IDX_PITCH_LOUD)) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction

  function automatic logic [4:0] periodOf(input logic [2:0] pitch);
    return 5'd16 + {1'b0, pitch[1:0], 2'b00};
  endfunction

  function automatic logic [4:0] highOf(input logic [2:0] pitch, input logic [2:0] lvl);
    return (pitch[1] ? 5'd12 : 5'd8) - {2'b00, lvl};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [7:0] wByte_q, wByte_d;
  logic wLane_q, wLane_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [7:0] rData_q, rData_d;
  logic toneEnable_q, toneEnable_d, decayEnable_q, decayEnable_d;
  logic stepSel_q, stepSel_d, lenSel_q, lenSel_d;
  logic [2:0] pitch_q, pitch_d, loud_q, loud_d, envLevel_q, envLevel_d;
  logic oscMeta_q, oscSync_q, oscLast_q;
  logic [DIV_W-1:0] div_q, div_d;
  logic unitPhase_q, unitPhase_d;
  logic [4:0] pwmCnt_q, pwmCnt_d;
  shot_state_t shot_q, shot_d;
  logic [5:0] shotCnt_q, shotCnt_d;
  logic pin_q, pin_d;

  logic doWrite, ctlWrite, plWrite, trigReq, abortReq;
  logic halfTick, tickSync, tickStep, unitTick;
  logic [2:0] level;
  logic [5:0] shotLen;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = {{(DATA_W-8){1'b0}}, rData_q};
  assign tonePin = pin_q;

  // ----------------------------------------------------------------
  // oscillator synchroniser and time base
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oscMeta_q <= 1'b0;
      oscSync_q <= 1'b0;
      oscLast_q <= 1'b0;
    end else begin
      oscMeta_q <= slowOscillator;
      oscSync_q <= oscMeta_q;
      oscLast_q <= oscSync_q;
    end
  end

  // either oscillator edge is one half period
  assign halfTick = oscSync_q ^ oscLast_q;
  assign tickSync = halfTick && ((div_q & DIV_W'(DIV_SYNC - 1)) == DIV_W'(DIV_SYNC - 1));
  assign tickStep = halfTick && (stepSel_q ?
    (div_q == DIV_W'(DIV_SLOW - 1)) :
    ((div_q & DIV_W'(DIV_FAST - 1)) == DIV_W'(DIV_FAST - 1)));
  // codes 4-7 count every second half period
  assign unitTick = halfTick && (!pitch_q[2] || unitPhase_q);
  assign level = decayEnable_q ? envLevel_q : loud_q;
  assign shotLen = lenSel_q ? SHOT_LONG_TICKS : SHOT_SHORT_TICKS;

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign ctlWrite = doWrite && wLane_q && (decodeIdx(awAddr_q) == 2'h1);
  assign plWrite = doWrite && wLane_q && (decodeIdx(awAddr_q) == 2'h2);
  assign abortReq = ctlWrite && wByte_q[CTL_ABORT];
  assign trigReq = ctlWrite && wByte_q[CTL_TRIGGER] && !wByte_q[CTL_TONE_EN]
    && !toneEnable_q;

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wByte_d = wByte_q;
    wLane_d = wLane_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    toneEnable_d = toneEnable_q;
    decayEnable_d = decayEnable_q;
    stepSel_d = stepSel_q;
    lenSel_d = lenSel_q;
    pitch_d = pitch_q;
    loud_d = loud_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
      wByte_d = s_axi_wdata[7:0];
      wLane_d = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = (decodeIdx(awAddr_q) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (ctlWrite) begin
      toneEnable_d = wByte_q[CTL_TONE_EN];
      decayEnable_d = wByte_q[CTL_DECAY_EN];
      stepSel_d = wByte_q[CTL_STEP_SEL];
      lenSel_d = wByte_q[CTL_LEN_SEL];
      if (wByte_q[CTL_TRIGGER]) begin
        decayEnable_d = 1'b0;
      end
    end
    if (plWrite) begin
      pitch_d = wByte_q[PL_PITCH_LSB +: 3];
      loud_d = wByte_q[PL_LOUD_LSB +: 3];
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rResp_d = RESP_OKAY;
      if (decodeIdx(s_axi_araddr) == 2'h1) begin
        // restart and abort are write-only and read 0
        rData_d = 8'h00;
        rData_d[CTL_TONE_EN] = toneEnable_q;
        rData_d[CTL_DECAY_EN] = decayEnable_q;
        rData_d[CTL_STEP_SEL] = stepSel_q;
        rData_d[CTL_LEN_SEL] = lenSel_q;
        rData_d[CTL_TRIGGER] = (shot_q != SHOT_IDLE);
      end else if (decodeIdx(s_axi_araddr) == 2'h2) begin
        rData_d = 8'h00;
        rData_d[PL_PITCH_LSB +: 3] = pitch_q;
        rData_d[PL_LOUD_LSB +: 3] = loud_q;
      end else begin
        rData_d = 8'h00;
        rResp_d = RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // envelope, one-shot and waveform
  // ----------------------------------------------------------------
  always_comb begin
    div_d = halfTick ? div_q + DIV_W'(1) : div_q;
    unitPhase_d = halfTick ? !unitPhase_q : unitPhase_q;
    pwmCnt_d = pwmCnt_q;
    if (pwmCnt_q >= periodOf(pitch_q)) begin
      pwmCnt_d = 5'd0;
    end else if (unitTick) begin
      pwmCnt_d = (pwmCnt_q == periodOf(pitch_q) - 5'd1) ? 5'd0 : pwmCnt_q + 5'd1;
    end
    envLevel_d = envLevel_q;
    if (!toneEnable_q || !decayEnable_q) begin
      envLevel_d = LEVEL_MAX;
    end else if (ctlWrite && wByte_q[CTL_DECAY_RST]) begin
      envLevel_d = LEVEL_MAX;
    end else if (tickStep && envLevel_q != LEVEL_MIN) begin
      envLevel_d = envLevel_q + 3'd1;
    end
    shot_d = shot_q;
    shotCnt_d = shotCnt_q;
    case (shot_q)
      SHOT_IDLE: begin
        if (trigReq) begin
          shot_d = SHOT_WAIT;
        end
      end
      SHOT_WAIT: begin
        if (tickSync) begin
          shot_d = SHOT_RUN;
          shotCnt_d = shotLen;
        end
      end
      SHOT_RUN: begin
        if (trigReq) begin
          shotCnt_d = shotLen;
        end else if (tickSync) begin
          shotCnt_d = shotCnt_q - 6'd1;
          if (shotCnt_q == 6'd1) begin
            shot_d = SHOT_IDLE;
          end
        end
      end
      default: begin
        shot_d = SHOT_IDLE;
      end
    endcase
    if (abortReq) begin
      shot_d = SHOT_IDLE;
    end
    pin_d = (toneEnable_q || shot_q == SHOT_RUN)
      && (pwmCnt_q < highOf(pitch_q, level));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q <= RESP_OKAY;
      rData_q <= 8'h00;
      toneEnable_q <= 1'b0;
      decayEnable_q <= 1'b0;
      stepSel_q <= 1'b0;
      lenSel_q <= 1'b0;
      pitch_q <= PITCH_RESET;
      loud_q <= LOUD_RESET;
      envLevel_q <= LEVEL_MAX;
      div_q <= '0;
      unitPhase_q <= 1'b0;
      pwmCnt_q <= 5'd0;
      shot_q <= SHOT_IDLE;
      shotCnt_q <= 6'd0;
      pin_q <= 1'b0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wByte_q <= wByte_d;
      wLane_q <= wLane_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      toneEnable_q <= toneEnable_d;
      decayEnable_q <= decayEnable_d;
      stepSel_q <= stepSel_d;
      lenSel_q <= lenSel_d;
      pitch_q <= pitch_d;
      loud_q <= loud_d;
      envLevel_q <= envLevel_d;
      div_q <= div_d;
      unitPhase_q <= unitPhase_d;
      pwmCnt_q <= pwmCnt_d;
      shot_q <= shot_d;
      shotCnt_q <= shotCnt_d;
      pin_q <= pin_d;
    end
  end
endmodule
`default_nettype wire

// File: verif/tone_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tone_checker #(
  parameter int ADDR_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [tone_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slowOscillator,
  input wire logic tonePin
);
  import tone_pkg::*;
  // ----
  // oscillator edges while high, last write seen
  // ----
  logic [2:0] oscQ, oscD;
  logic [4:0] hiQ, hiD;
  logic [ADDR_W-1:0] adrQ, adrD;
  logic [8:0] datQ, datD;
  logic wroteQ, wroteD;
  always_comb begin
    oscD = {oscQ[1:0], slowOscillator};
    hiD = tonePin ? hiQ + 5'(oscQ[2] ^ oscQ[1] && hiQ != 5'h1f) : 5'h0;
    adrD = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : adrQ;
    datD = s_axi_wvalid && s_axi_wready ? {s_axi_wstrb[0], s_axi_wdata[7:0]} : datQ;
    wroteD = wroteQ | s_axi_bvalid;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {oscQ, hiQ, adrQ, datQ, wroteQ} <= '0;
    end else begin
      {oscQ, hiQ, adrQ, datQ, wroteQ} <= {oscD, hiD, adrD, datD, wroteD};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_abort;
    $rose(s_axi_bvalid) && adrQ == ADDR_W'(IDX_CONTROL * 4) && datQ[8]
      && datQ[CTL_ABORT] && !datQ[CTL_TONE_EN];
  endsequence
  sequence s_quiet;
    !tonePin [*8];
  endsequence
  property p_reset_quiet;
    $fell(rst) |-> !tonePin [*2];
  endproperty
  property p_idle;
    !wroteQ |-> !tonePin;
  endproperty
  property p_high_bound;
    hiQ <= 5'd25;
  endproperty
  property p_abort;
    s_abort |-> ##[1:3] s_quiet;
  endproperty
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rd_close;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pin high after reset");
  a_idle: assert property (p_idle) else $error("pin high before any write");
  a_high_bound: assert property (p_high_bound) else $error("high time too long");
  a_abort: assert property (p_abort) else $error("pin not low after stop");
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_wr_refuse: assert property (p_wr_refuse) else $error("write taken early");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_close: assert property (p_rd_close) else $error("read answer stuck");
endmodule
bind buzzer_tone_generator tone_checker #(.ADDR_W(ADDR_W)) props (.*);
`default_nettype wire

// File: verif/buzzer_model.sv
`timescale 1ns/10ps
`default_nettype none
module buzzer_model (
  input wire logic clock,
  input wire logic tonePin,
  output int highClk,
  output int periodClk,
  output int rises
);
  // ----
  // measures high time and period of the pin in clocks
  // ----
  int cnt = 0;
  logic prevQ = 1'b0;
  always @(posedge clock) begin
    cnt <= cnt + 1;
    prevQ <= tonePin;
    if (tonePin && !prevQ) begin
      periodClk <= cnt;
      cnt <= 1;
      rises <= rises + 1;
    end
    if (!tonePin && prevQ) highClk <= cnt;
  end
endmodule
`default_nettype wire

// File: verif/buzzer_tone_generator_tb.sv
`timescale 1ns/10ps
`default_nettype none
module buzzer_tone_generator_tb;
  import tone_pkg::*;
  localparam int HALF = 4;
  localparam int TICK = 256 * HALF;
  typedef struct {logic [2:0] p; logic [2:0] l; int hi; int per;} row_t;
  row_t rows[8] = '{'{3'h0, 3'h0, 8, 16}, '{3'h1, 3'h3, 5, 20}, '{3'h2, 3'h6, 6, 24},
    '{3'h3, 3'h1, 11, 28}, '{3'h4, 3'h4, 4, 16}, '{3'h5, 3'h7, 1, 20},
    '{3'h6, 3'h2, 10, 24}, '{3'h7, 3'h5, 7, 28}};
  logic clock = 0, rst = 1, slowOscillator = 0, tonePin;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int oscCnt = 0, nErrors = 0, comparisons = 0, highClk, periodClk, rises, n0;
  time t0;
  buzzer_tone_generator dut (.*);
  buzzer_model model (.clock, .tonePin, .highClk, .periodClk, .rises);
  // ----
  // clocks, bus tasks, checks
  // ----
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    oscCnt <= oscCnt == HALF - 1 ? 0 : oscCnt + 1;
    if (oscCnt == HALF - 1) slowOscillator <= ~slowOscillator;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input int idx, input logic [7:0] v, output logic [1:0] resp);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awaddr <= 20'(idx * 4);
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    repeat (64) begin
      @(negedge clock);
      {ta, tw, tb, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clock);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) begin
        s_axi_bready <= 0;
        return;
      end
    end
    nErrors++;
    give_verdict();
  endtask
  task automatic rd(input int idx, output logic [31:0] v, output logic [1:0] resp);
    logic ta, tr;
    @(posedge clock);
    s_axi_araddr <= 20'(idx * 4);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    repeat (64) begin
      @(negedge clock);
      {ta, tr, v, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clock);
      if (ta) s_axi_arvalid <= 0;
      if (tr) begin
        s_axi_rready <= 0;
        return;
      end
    end
    nErrors++;
    give_verdict();
  endtask
  task automatic w(input int idx, input logic [7:0] v);
    wr(idx, v, rs);
    check("bresp", 32'(RESP_OKAY), 32'(rs));
  endtask
  task automatic r(input int idx, input logic [7:0] exp);
    rd(idx, d, rs);
    check("rdata", {24'h0, exp}, d);
    check("rresp", 32'(RESP_OKAY), 32'(rs));
  endtask
  task automatic wave(input int hi, input int per, input int m);
    repeat (3 * per * m * HALF + 20) @(posedge clock);
    check("high", 32'(hi * m * HALF), 32'(highClk));
    check("period", 32'(per * m * HALF), 32'(periodClk));
  endtask
  task automatic busy_for(input int lo, input int hi);
    int n;
    for (n = 0; n < 10000 && d[5] !== 1'b0; n++) rd(IDX_CONTROL, d, rs);
    if (n == 10000) begin
      nErrors++;
      give_verdict();
    end
    check("burst", 1, 32'($time - t0 >= (lo * TICK - 20) * 5 && $time - t0 <= (hi * TICK + 200) * 5));
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 0;
    w(IDX_CONTROL, 8'h01);
    foreach (rows[i]) begin
      w(IDX_PITCH_LOUD, {1'b0, rows[i].l, 1'b0, rows[i].p});
      wave(rows[i].hi, rows[i].per, rows[i].p[2] ? 2 : 1);
    end
    $display("test table done");
    rst <= 1;
    repeat (8) @(posedge clock);
    check("pin", 0, 32'(tonePin));
    rst <= 0;
    r(IDX_CONTROL, 8'h00);
    r(IDX_PITCH_LOUD, 8'h00);
    $display("test reset done");
    w(IDX_PITCH_LOUD, 8'h70);
    w(IDX_CONTROL, 8'h03);
    wave(8, 16, 1);
    repeat (16384) @(posedge clock);
    wave(7, 16, 1);
    // slow steps: one step by the next lone fast tick, not two
    w(IDX_CONTROL, 8'h0f);
    wave(8, 16, 1);
    repeat (32768) @(posedge clock);
    wave(7, 16, 1);
    $display("test envelope done");
    w(IDX_CONTROL, 8'hcc);
    r(IDX_CONTROL, 8'h08);
    wr('hff46, 8'h01, rs);
    check("bresp", 32'(RESP_SLVERR), 32'(rs));
    rd('hff46, d, rs);
    check("rdata", 0, d);
    check("rresp", 32'(RESP_SLVERR), 32'(rs));
    $display("test map done");
    w(IDX_CONTROL, 8'h02);
    t0 = $time;
    n0 = rises;
    w(IDX_CONTROL, 8'h22);
    r(IDX_CONTROL, 8'h20);
    busy_for(8, 9);
    check("sound", 1, 32'(rises > n0));
    t0 = $time;
    w(IDX_CONTROL, 8'h20);
    repeat (5 * TICK) @(posedge clock);
    w(IDX_CONTROL, 8'h20);
    d = '1;
    busy_for(12, 14);
    w(IDX_CONTROL, 8'h30);
    repeat (10 * TICK) @(posedge clock);
    r(IDX_CONTROL, 8'h30);
    w(IDX_CONTROL, 8'h50);
    r(IDX_CONTROL, 8'h10);
    w(IDX_CONTROL, 8'h60);
    r(IDX_CONTROL, 8'h00);
    w(IDX_CONTROL, 8'h01);
    w(IDX_CONTROL, 8'h21);
    r(IDX_CONTROL, 8'h01);
    w(IDX_CONTROL, 8'h20);
    r(IDX_CONTROL, 8'h00);
    w(IDX_CONTROL, 8'h00);
    $display("test one-shot done");
    give_verdict();
  end
endmodule
`default_nettype wire
